// *** rtl/brownout_power_ctrl.sv ***
// Brownout detection, idle and power-down control with its four SFRs and an event interrupt.
// Assumes the CPU issues SFR accesses on clk_i; pins and the supply comparator are asynchronous.
//
// Contract
// [R1] Detection off after external reset until enabled
// [R2] Enabled low supply while active: flag, internal reset
// [R3] External reset clears flag; brownout reset keeps it
// [R4] Trim bits reset to 001; software keeps them
// [R5] Length field selects brownout reset duration
// [R6] Brownout control bit 1 reserved, reads zero
// [R7] Sleep bit gates CPU and peripheral clocks
// [R8] Idle keeps CPU state and port levels
// [R9] Enabled interrupt clears sleep bit, ends idle; code wakes on any irq_wake_i, IMSK not consulted
// [R10] Two user flags, read/write, no function
// [R11] Power-down bit stops the oscillator, ports hold
// [R12] Only hardware reset leaves power-down
// [R13] Outside reset held until oscillator is stable
// [R14] Baud doubler bit doubles serial baud rate
// [R15] Pin sampled per machine cycle, two highs reset
// [R16] Brownout reset lengths are design parameters
`timescale 1ns/1ps
module brownout_power_ctrl
  import pwr_pkg::*;
#(
  parameter int unsigned BO_LEN0 = 16,
  parameter int unsigned BO_LEN1 = 32,
  parameter int unsigned BO_LEN2 = 64,
  parameter int unsigned BO_LEN3 = 128
)(
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  input  wire sfr_req_t   req_i,
  input  wire logic       ext_reset_i,
  input  wire logic       supply_low_i,
  input  wire logic       irq_wake_i,
  output logic [7:0]      rdata_o,
  output logic            cpu_clk_en_o,
  output logic            periph_clk_en_o,
  output logic            osc_run_o,
  output logic            port_hold_o,
  output logic            sys_reset_o,
  output logic            baud_double_o,
  output logic            irq_o
);

  if (BO_LEN0 < 1 || BO_LEN1 < 1 || BO_LEN2 < 1 || BO_LEN3 < 1 ||
      BO_LEN0 > 65535 || BO_LEN1 > 65535 || BO_LEN2 > 65535 || BO_LEN3 > 65535)
  begin : g_len_chk
    $error("brownout reset lengths must be 1 to 65535 cycles");
  end

  typedef struct packed {
    logic             rst_s1;
    logic             rst_s2;
    logic             low_s1;
    logic             low_s2;
    logic [3:0]       mc_cnt;
    logic [1:0]       ext_cnt;
    logic             ext_active;
    pwr_state_t       state;
    pctl_t            pctl;
    bctl_t            bctl;
    logic [IRQ_W-1:0] ist;
    logic [IRQ_W-1:0] imsk;
    logic [15:0]      bo_cnt;
    logic [7:0]       rdata;
    logic             cpu_en;
    logic             osc_run;
    logic             port_hold;
    logic             sys_rst;
    logic             baud;
    logic             irq;
  } st_t;

  st_t  r;
  st_t  n;
  logic rst_q1;
  logic rst_n;

  function automatic logic [15:0] len_sel(input logic [1:0] sel);
    case (sel)
      2'h0:    len_sel = 16'(BO_LEN0);
      2'h1:    len_sel = 16'(BO_LEN1);
      2'h2:    len_sel = 16'(BO_LEN2);
      default: len_sel = 16'(BO_LEN3);
    endcase
  endfunction

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end
    else
    begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  always_comb
  begin
    n        = r;
    n.rst_s1 = ext_reset_i;
    n.rst_s2 = r.rst_s1;
    n.low_s1 = supply_low_i;
    n.low_s2 = r.low_s1;
    n.rdata  = 8'h00;

    // Frozen oscillator: no machine cycles during power-down
    if (r.state != ST_PDOWN)
    begin
      n.mc_cnt = (r.mc_cnt == MC_LAST) ? 4'h0 : r.mc_cnt + 4'h1;
      if (r.mc_cnt == MC_LAST)
      begin
        if (!r.rst_s2)
          n.ext_cnt = 2'h0; // see [R15]
        else if (r.ext_cnt != EXT_RST_MC)
          n.ext_cnt = r.ext_cnt + 2'h1; // see [R15]
      end
    end
    n.ext_active = (n.ext_cnt == EXT_RST_MC); // see [R15]

    if (req_i.rd)
    begin
      case (req_i.addr)
        PCTL_ADDR: n.rdata = r.pctl;
        BCTL_ADDR: n.rdata = r.bctl; // see [R6]
        IST_ADDR:  n.rdata = {6'h00, r.ist};
        IMSK_ADDR: n.rdata = {6'h00, r.imsk};
        default:   n.rdata = 8'h00;
      endcase
    end

    if (req_i.wr && r.state == ST_ACTIVE && !r.ext_active)
    begin
      case (req_i.addr)
        PCTL_ADDR:
        begin
          n.pctl.baud_doubler      = req_i.wdata[7]; // see [R14]
          n.pctl.user_flag_one     = req_i.wdata[3]; // see [R10]
          n.pctl.user_flag_zero    = req_i.wdata[2]; // see [R10]
          n.pctl.power_down_bit    = req_i.wdata[1];
          n.pctl.sleep_request_bit = req_i.wdata[0];
          // Power-down wins if both bits are written together
          if (req_i.wdata[1])
            n.state = ST_PDOWN; // see [R11]
          else if (req_i.wdata[0])
            n.state = ST_IDLE; // see [R7]
        end
        BCTL_ADDR:
        begin
          n.bctl.brownout_enable   = req_i.wdata[7]; // see [R1]
          n.bctl.trim_setting      = req_i.wdata[6:4]; // see [R4]
          n.bctl.fail_reset_length = req_i.wdata[3:2]; // see [R5]
        end
        IST_ADDR:  n.ist  = r.ist & ~req_i.wdata[IRQ_W-1:0];
        IMSK_ADDR: n.imsk = req_i.wdata[IRQ_W-1:0];
        default:   n.imsk = r.imsk;
      endcase
    end

    case (r.state)
      ST_ACTIVE:
      begin
        if (r.bctl.brownout_enable && r.low_s2)
        begin
          n.bctl.brownout_flag = 1'b1; // see [R2]
          n.ist[IRQ_BO]        = 1'b1;
          n.state              = ST_BORST; // see [R2]
          n.bo_cnt             = len_sel(r.bctl.fail_reset_length); // see [R5] [R16]
        end
      end
      ST_IDLE:
      begin
        // Registers frozen: only the wake path and the pin reset touch them
        if (irq_wake_i)
        begin
          n.pctl.sleep_request_bit = 1'b0; // see [R9]
          n.ist[IRQ_WAKE]          = 1'b1;
          n.state                  = ST_ACTIVE; // see [R9]
        end
      end
      ST_PDOWN:
      begin
        // Pin alone restarts the oscillator; the outside party holds it long enough
        if (r.rst_s2)
          n.state = ST_ACTIVE; // see [R12] [R13]
      end
      ST_BORST:
      begin
        // PCTL and BCTL reinitialised, but the cause stays visible
        n.pctl   = PCTL_RST;
        n.bctl   = {BCTL_RST[7:1], r.bctl.brownout_flag}; // see [R3]
        n.bo_cnt = r.bo_cnt - 16'h1;
        if (r.bo_cnt <= 16'h1)
          n.state = ST_ACTIVE;
      end
      default: n.state = ST_ACTIVE;
    endcase

    if (n.ext_active)
    begin
      n.pctl   = PCTL_RST; // see [R12]
      n.bctl   = BCTL_RST; // see [R1] [R3] [R4]
      n.ist    = '0;
      n.imsk   = '0;
      n.bo_cnt = 16'h0;
      n.state  = ST_ACTIVE;
    end

    n.cpu_en    = (n.state == ST_ACTIVE) && !n.ext_active; // see [R7] [R8]
    n.osc_run   = (n.state != ST_PDOWN); // see [R11]
    n.port_hold = (n.state == ST_IDLE) || (n.state == ST_PDOWN); // see [R8] [R11]
    n.sys_rst   = n.ext_active || (n.state == ST_BORST); // see [R2] [R15]
    n.baud      = n.pctl.baud_doubler; // see [R14]
    n.irq       = |(n.ist & n.imsk);
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r         <= '0;
      r.state   <= ST_ACTIVE;
      r.bctl    <= BCTL_RST;
      r.pctl    <= PCTL_RST;
      r.osc_run <= 1'b1;
      r.cpu_en  <= 1'b1;
    end
    else
      r <= n;
  end

  assign rdata_o         = r.rdata;
  assign cpu_clk_en_o    = r.cpu_en;
  assign periph_clk_en_o = r.cpu_en;
  assign osc_run_o       = r.osc_run;
  assign port_hold_o     = r.port_hold;
  assign sys_reset_o     = r.sys_rst;
  assign baud_double_o   = r.baud;
  assign irq_o           = r.irq;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  property p_r1_off;
    !r.bctl.brownout_enable && r.state == ST_ACTIVE |=> r.state != ST_BORST;
  endproperty
  a_r1_off: assert property (p_r1_off) else $error("brownout reset while detection off"); // see [R1]

  property p_r2_trip;
    r.state == ST_ACTIVE && r.bctl.brownout_enable && r.low_s2 && !n.ext_active
      |=> r.bctl.brownout_flag && sys_reset_o && !cpu_clk_en_o;
  endproperty
  a_r2_trip: assert property (p_r2_trip) else $error("low supply did not trip reset"); // see [R2]

  property p_r3_keep;
    r.state == ST_BORST && !n.ext_active |=> r.bctl.brownout_flag;
  endproperty
  a_r3_keep: assert property (p_r3_keep) else $error("brownout reset lost the flag"); // see [R3]

  property p_r4_trim;
    $fell(r.ext_active) |-> r.bctl.trim_setting == TRIM_RST && r.bctl.fail_reset_length == LEN_RST
      && !r.bctl.brownout_flag;
  endproperty
  a_r4_trim: assert property (p_r4_trim) else $error("trim or flag wrong after reset"); // see [R4]

  property p_r6_rsvd;
    req_i.rd && req_i.addr == BCTL_ADDR |=> !rdata_o[1];
  endproperty
  a_r6_rsvd: assert property (p_r6_rsvd) else $error("reserved bit read as one"); // see [R6]

  property p_r7_idle;
    // Power-down wins over idle, so a write of both bits is left to the power-down check
    req_i.wr && req_i.addr == PCTL_ADDR && req_i.wdata[0] && !req_i.wdata[1] && r.state == ST_ACTIVE
      && !r.ext_active && !n.ext_active
      |=> !cpu_clk_en_o && !periph_clk_en_o && osc_run_o;
  endproperty
  a_r7_idle: assert property (p_r7_idle) else $error("idle did not gate clocks"); // see [R7]

  property p_r9_wake;
    r.state == ST_IDLE && irq_wake_i |=> !r.pctl.sleep_request_bit && (cpu_clk_en_o || sys_reset_o);
  endproperty
  a_r9_wake: assert property (p_r9_wake) else $error("interrupt did not end idle"); // see [R9]

  property p_r11_pd;
    // A brownout trip in the same cycle takes precedence over power-down
    req_i.wr && req_i.addr == PCTL_ADDR && req_i.wdata[1] && r.state == ST_ACTIVE && !r.ext_active
      && !n.ext_active && !(r.bctl.brownout_enable && r.low_s2)
      |=> !osc_run_o && port_hold_o;
  endproperty
  a_r11_pd: assert property (p_r11_pd) else $error("power-down did not stop oscillator"); // see [R11]

  property p_r12_stay;
    r.state == ST_PDOWN && !r.rst_s2 |=> r.state == ST_PDOWN;
  endproperty
  a_r12_stay: assert property (p_r12_stay) else $error("power-down left without reset"); // see [R12]

  property p_r14_baud;
    req_i.wr && req_i.addr == PCTL_ADDR && r.state == ST_ACTIVE && !r.ext_active && !n.ext_active
      |=> baud_double_o == $past(req_i.wdata[7]);
  endproperty
  a_r14_baud: assert property (p_r14_baud) else $error("baud doubler output mismatch"); // see [R14]

  property p_r15_ext;
    $rose(r.ext_active) |-> sys_reset_o && $past(r.rst_s2);
  endproperty
  a_r15_ext: assert property (p_r15_ext) else $error("pin reset without high sample"); // see [R15]

endmodule

// *** rtl/pwr_pkg.sv ***
// Constants, register layouts and state codes of the brownout and power-saving controller.
// Assumes an 8-bit special function register space on a single clock.
package pwr_pkg;

  localparam logic [7:0] PCTL_ADDR = 8'h87;
  localparam logic [7:0] BCTL_ADDR = 8'hD6;
  localparam logic [7:0] IST_ADDR  = 8'hE9;
  localparam logic [7:0] IMSK_ADDR = 8'hEA;

  localparam logic [7:0] PCTL_RST  = 8'h00;
  localparam logic [7:0] BCTL_RST  = 8'h10;
  localparam logic [2:0] TRIM_RST  = 3'h1;
  localparam logic [1:0] LEN_RST   = 2'h0;

  localparam int IRQ_BO   = 0;
  localparam int IRQ_WAKE = 1;
  localparam int IRQ_W    = 2;

  // Oscillator periods per machine cycle, and machine cycles of pin high for a reset
  localparam int         MC_CLKS    = 12;
  localparam logic [3:0] MC_LAST    = 4'(MC_CLKS - 1);
  localparam logic [1:0] EXT_RST_MC = 2'h2;

  typedef struct packed {
    logic       baud_doubler;
    logic [2:0] rsvd;
    logic       user_flag_one;
    logic       user_flag_zero;
    logic       power_down_bit;
    logic       sleep_request_bit;
  } pctl_t;

  typedef struct packed {
    logic       brownout_enable;
    logic [2:0] trim_setting;
    logic [1:0] fail_reset_length;
    logic       rsvd;
    logic       brownout_flag;
  } bctl_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sfr_req_t;

  typedef enum logic [3:0] {
    ST_ACTIVE = 4'b0001,
    ST_IDLE   = 4'b0010,
    ST_PDOWN  = 4'b0100,
    ST_BORST  = 4'b1000
  } pwr_state_t;

endpackage

// *** verif/pwr_partner.sv ***
// Far-side model: pin reset source and interrupt logic around the controller.
// Assumes the bench requests wake-ups and reset pulses just after a rising edge.
`timescale 1ns/1ps
module pwr_partner (
  input  wire logic clk_i,
  input  wire logic cpu_clk_en_i,
  input  wire logic osc_run_i,
  input  wire logic wake_req_i,
  input  wire logic rst_go_i,
  input  wire logic [15:0] rst_len_i,
  output logic      ext_reset_o,
  output logic      irq_wake_o = 1'b0
);
  int left = 0;
  // Pending only while the CPU is gated, as a source waiting for service
  always @(posedge clk_i)
    irq_wake_o <= wake_req_i && !cpu_clk_en_i;
  // Counts only while the oscillator runs, so the pin outlasts a restart
  always @(posedge clk_i)
    if (rst_go_i)
      left <= rst_len_i;
    else if (left > 0 && osc_run_i)
      left <= left - 1;
  assign ext_reset_o = (left > 0);
endmodule

// *** verif/brownout_and_power_saving_ctrl_tb.sv ***
// Self-checking bench of the brownout and power-saving controller.
// Assumes the partner model drives the reset pin and the wake-up line.
`timescale 1ns/1ps
module brownout_and_power_saving_ctrl_tb;
  import pwr_pkg::*;
  localparam int LEN [4] = '{3, 5, 7, 9};
  logic       clk_i = 1'b0;
  logic       arst_n_i = 1'b0;
  sfr_req_t   req = '0;
  logic       supply_low = 1'b0;
  logic       wake_req = 1'b0;
  logic       rst_go = 1'b0;
  logic [15:0] rst_len = 16'h0000;
  logic       ext_reset, irq_wake, cpu_en, per_en, osc_run, hold, sys_rst, baud, irq;
  logic [7:0] rdata;
  int         err_count = 0;
  int         cmp_count = 0;
  int         n;
  int         seen;

  brownout_power_ctrl #(.BO_LEN0(LEN[0]), .BO_LEN1(LEN[1]), .BO_LEN2(LEN[2]), .BO_LEN3(LEN[3])) u_dut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .req_i(req), .ext_reset_i(ext_reset),
    .supply_low_i(supply_low), .irq_wake_i(irq_wake), .rdata_o(rdata), .cpu_clk_en_o(cpu_en),
    .periph_clk_en_o(per_en), .osc_run_o(osc_run), .port_hold_o(hold), .sys_reset_o(sys_rst),
    .baud_double_o(baud), .irq_o(irq));
  pwr_partner u_far (
    .clk_i(clk_i), .cpu_clk_en_i(cpu_en), .osc_run_i(osc_run), .wake_req_i(wake_req),
    .rst_go_i(rst_go), .rst_len_i(rst_len), .ext_reset_o(ext_reset), .irq_wake_o(irq_wake));

  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    req.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    req.rd <= 1'b0;
    #1;
    chk($sformatf("read %h", a), rdata, exp);
  endtask

  task automatic t_regs();
    rd(PCTL_ADDR, 8'h00);
    rd(BCTL_ADDR, 8'h10);
    rd(8'h00, 8'h00);
    // Trim kept at its reset pattern; reserved bit and flag written as ones
    wr(BCTL_ADDR, 8'h1F);
    rd(BCTL_ADDR, 8'h1C);
    wr(BCTL_ADDR, 8'h10);
    wr(PCTL_ADDR, 8'hFC);
    rd(PCTL_ADDR, 8'h8C);
    chk("baud", 8'(baud), 8'h01);
  endtask
  task automatic t_brownout();
    @(posedge clk_i);
    supply_low <= 1'b1;
    repeat (10) tick();
    chk("no detect", 8'(sys_rst), 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      wr(BCTL_ADDR, 8'h90 | 8'(i << 2));
      for (n = 0; n < 20 && sys_rst !== 1'b1; n++) tick();
      chk("bo reset", 8'(sys_rst), 8'h01);
      for (n = 0; n < 40 && sys_rst === 1'b1; n++) tick();
      chk("bo length", 8'(n), 8'(LEN[i]));
    end
    @(posedge clk_i);
    supply_low <= 1'b0;
    rd(BCTL_ADDR, 8'h11);
    rd(PCTL_ADDR, 8'h00);
    rd(IST_ADDR, 8'h01);
    wr(IMSK_ADDR, 8'h01);
    tick();
    chk("irq set", 8'(irq), 8'h01);
    wr(IST_ADDR, 8'h01);
    tick();
    chk("irq clear", 8'(irq), 8'h00);
    wr(IMSK_ADDR, 8'h02);
  endtask
  task automatic t_idle();
    wr(PCTL_ADDR, 8'h01);
    chk("idle gate", 8'({cpu_en, per_en, osc_run, hold}), 8'h03);
    wr(PCTL_ADDR, 8'h0C);
    @(posedge clk_i);
    wake_req <= 1'b1;
    for (n = 0; n < 30 && cpu_en !== 1'b1; n++) tick();
    chk("wake", 8'({cpu_en, hold, irq}), 8'h05);
    @(posedge clk_i);
    wake_req <= 1'b0;
    rd(PCTL_ADDR, 8'h00);
    rd(IST_ADDR, 8'h02);
    wr(IST_ADDR, 8'h02);
  endtask
  task automatic t_pin();
    @(posedge clk_i);
    rst_len <= 16'h0008;
    rst_go <= 1'b1;
    @(posedge clk_i);
    rst_go <= 1'b0;
    seen = 0;
    repeat (40)
    begin
      tick();
      if (sys_rst !== 1'b0) seen = 1;
    end
    chk("short pin", 8'(seen), 8'h00);
    wr(PCTL_ADDR, 8'h03);
    chk("pdown", 8'({cpu_en, osc_run, hold}), 8'h01);
    @(posedge clk_i);
    wake_req <= 1'b1;
    repeat (20) tick();
    chk("no wake", 8'(osc_run), 8'h00);
    @(posedge clk_i);
    wake_req <= 1'b0;
    rst_len <= 16'h0028;
    rst_go <= 1'b1;
    @(posedge clk_i);
    rst_go <= 1'b0;
    for (n = 0; n < 200 && sys_rst !== 1'b1; n++) tick();
    chk("pin reset", 8'({osc_run, sys_rst}), 8'h03);
    for (n = 0; n < 400 && sys_rst === 1'b1; n++) tick();
    repeat (4) tick();
    rd(BCTL_ADDR, 8'h10);
    rd(PCTL_ADDR, 8'h00);
    rd(IMSK_ADDR, 8'h00);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    forever #20 clk_i = ~clk_i;
  end
  // Whole run is a few hundred cycles; this limit is far beyond it
  initial
  begin
    #400us;
    err_count++;
    complete_run();
  end
  initial
  begin
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    t_regs();
    t_brownout();
    t_idle();
    t_pin();
    complete_run();
  end
endmodule
